// ==== fsps_params.svh ====
`ifndef FSPS_PARAMS_SVH
`define FSPS_PARAMS_SVH
// ==========================================
// Register offsets (byte addresses)
`define FSPS_OFF_CMD      12'h000
`define FSPS_OFF_CTRLA    12'h004
`define FSPS_OFF_STATUS   12'h008
`define FSPS_OFF_ADDR     12'h00C
`define FSPS_OFF_DATA     12'h010
`define FSPS_OFF_UNLOCK   12'h014
`define FSPS_OFF_LOCK     12'h018
// ==========================================
// Field positions
`define FSPS_CTRLA_EXEC   0
`define FSPS_STAT_BUSY    7
`define FSPS_STAT_FLASH_SECTION_BUSY_FLAG   0
`define FSPS_STAT_ABORT   1
// ==========================================
// Unlock key and window
`define FSPS_UNLOCK_KEY   8'h9D
`define FSPS_UNLOCK_CYC   4
// ==========================================
// Geometry: 32 pages of 16 words, app pages 0..23, boot 24..31
`define FSPS_PAGES        32
`define FSPS_WORDS        16
`define FSPS_BOOT_FIRST   5'h18
`define FSPS_ERASED_WORD  16'hFFFF
// ==========================================
// Operation timing in cycles
`define FSPS_ERASE_CYC    16'h0040
`define FSPS_WRITE_CYC    16'h0040
`define FSPS_BUF_CYC      16'h0010
// ==========================================
// Command codes
`define FSPS_CMD_NOP      7'h00
`define FSPS_CMD_RDSIG    7'h01
`define FSPS_CMD_ERSIG    7'h18
`define FSPS_CMD_WRSIG    7'h1A
`define FSPS_CMD_ERAPP    7'h20
`define FSPS_CMD_ERAPPPG  7'h22
`define FSPS_CMD_LDBUF    7'h23
`define FSPS_CMD_WRAPPPG  7'h24
`define FSPS_CMD_EWAPPPG  7'h25
`define FSPS_CMD_ERBUF    7'h26
`define FSPS_CMD_ERBOOTPG 7'h2A
`define FSPS_CMD_ERPG     7'h2B
`define FSPS_CMD_WRBOOTPG 7'h2C
`define FSPS_CMD_EWBOOTPG 7'h2D
`define FSPS_CMD_WRPG     7'h2E
`define FSPS_CMD_EWPG     7'h2F
`define FSPS_CMD_APPCRC   7'h38
`define FSPS_CMD_BOOTCRC  7'h39
`define FSPS_CMD_RNGCRC   7'h3A
`endif

// ==== fsps_pkg.sv ====
package fsps_pkg;
	typedef enum logic [3:0]
	{
		FSPS_IDLE   = 4'h0,
		FSPS_BUFCLR = 4'h1,
		FSPS_ERASE  = 4'h2,
		FSPS_WRITE  = 4'h3,
		FSPS_CRC    = 4'h4,
		FSPS_ERAPP  = 4'h5,
		FSPS_SIGCLR = 4'h6
	} fsps_state_t;
	typedef enum logic [1:0]
	{
		FSPS_TGT_ANY  = 2'h0,
		FSPS_TGT_APP  = 2'h1,
		FSPS_TGT_BOOT = 2'h2,
		FSPS_TGT_SIG  = 2'h3
	} fsps_target_t;
endpackage

// ==== fsps_crc_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface fsps_crc_if;
	logic        clear;
	logic        step;
	logic [15:0] word;
	logic [31:0] value;
	modport engine (input clear, input step, input word, output value);
	modport user (output clear, output step, output word, input value);
endinterface
`default_nettype wire

// ==== fsps_crc.sv ====
`timescale 1ns/100ps
`default_nettype none
module fsps_crc
(
	input  wire logic  clk,
	input  wire logic  reset,
	fsps_crc_if.engine crc
);
	logic [31:0] crc_q;
	logic [31:0] crc_d;
	// ==========================================
	// CRC-32 shift, one data bit per loop pass
	always_comb
	begin
		crc_d = crc_q;
		for (int i = 0; i < 16; i++)
			crc_d = {crc_d[30:0], 1'b0} ^ ((crc_d[31] ^ crc.word[i]) ? 32'h04C11DB7 : 32'h0);
	end
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			crc_q <= 32'hFFFFFFFF;
		else if (crc.clear)
			crc_q <= 32'hFFFFFFFF;
		else if (crc.step)
			crc_q <= crc_d;
	end
	assign crc.value = crc_q;
endmodule
`default_nettype wire

// ==== fsps_page_buf.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "fsps_params.svh"
module fsps_page_buf
(
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        clear,
	input  wire logic        load,
	input  wire logic [3:0]  load_idx,
	input  wire logic [15:0] load_word,
	input  wire logic [3:0]  rd_idx,
	output logic      [15:0] rd_word
);
	logic [15:0] buf_q [`FSPS_WORDS];
	// ==========================================
	// Erased or never loaded words read all ones
	generate
		for (genvar g = 0; g < `FSPS_WORDS; g++)
		begin : g_word
			always_ff @(posedge clk or posedge reset)
			begin
				if (reset)
					buf_q[g] <= `FSPS_ERASED_WORD;
				else if (clear)
					buf_q[g] <= `FSPS_ERASED_WORD;
				else if (load && load_idx == 4'(g))
					buf_q[g] <= load_word;
			end
		end
	endgenerate
	assign rd_word = buf_q[rd_idx];
endmodule
`default_nettype wire

// ==== fsps_sequencer.sv ====
// How it works
// [RL1] Load with no-op command returns flash byte at the pointer byte address.
// [RL2] Execute bit with buffer-erase command clears the buffer, busy until done.
// [RL3] Store with load command writes R1:R0 word to buffer, no unlock needed.
// [RL4] Words not loaded since last buffer erase commit as all ones.
// [RL5] Page erase by store erases the pointer page, word bits ignored, bits above the page must be zero.
// [RL6] Page erase or write keeps busy and flash-busy until finished.
// [RL7] Page write by store copies the whole buffer into the pointer page.
// [RL8] Protected commands start only after a timed unlock by the core.
// [RL9] Range CRC uses address as start, data as end; busy and core halted.
// [RL10] Range CRC result lands in the data register.
// [RL11] Range CRC aborts when any boot lock bit is programmed.
// [RL12] Application erase wipes all app pages, busy and halt throughout.
// [RL13] Section page commands abort on pages outside their section.
// [RL14] Erase-and-write commands erase then program the page atomically.
// [RL15] Section CRCs by execute bit set busy, halt core, leave checksum.
// [RL16] Signature row erase keeps busy and halt until done.
// [RL17] Signature write halts the core, then clears buffer without halt.
// [RL18] Execute bit, load and store each trigger their own command kinds.
// [RL19] New triggers are ignored while busy.
`timescale 1ns/100ps
`default_nettype none
`include "fsps_params.svh"
module fsps_sequencer
(
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        lpm_req,
	input  wire logic        spm_req,
	input  wire logic [23:0] z_pointer,
	input  wire logic [15:0] spm_word,
	output logic      [7:0]  lpm_data,
	output logic             lpm_valid,
	output logic             core_halt,
	output logic             busy_flag,
	output logic             flash_section_busy_flag
);
	// ==========================================
	// Registers
	logic [6:0]  cmd_q;
	logic [23:0] addr_q;
	logic [31:0] data_q;
	logic [7:0]  lock_q;
	logic        abort_q;
	logic [2:0]  unlock_q;
	logic        busy_q;
	logic        flash_section_busy_flag_q;
	logic        halt_q;
	logic [31:0] prdata_q;
	logic        pready_q;
	logic        pslverr_q;
	logic [7:0]  lpm_data_q;
	logic        lpm_valid_q;
	fsps_pkg::fsps_state_t state_q;
	logic [15:0] timer_q;
	logic [4:0]  page_q;
	logic [3:0]  widx_q;
	logic        wr_after_q;
	logic        all_app_q;
	logic [8:0]  crc_end_q;
	logic [8:0]  crc_pos_q;
	logic        crc_fin_q;
	logic [15:0] flash_q [`FSPS_PAGES * `FSPS_WORDS];
	logic [15:0] sig_q [`FSPS_WORDS];
	// ==========================================
	// APB decode
	logic apb_wr;
	logic apb_setup;
	logic exec_set;
	logic unlocked;
	assign apb_setup = psel && !penable;
	assign apb_wr = psel && penable && pready_q && pwrite;
	assign exec_set = apb_wr && paddr == `FSPS_OFF_CTRLA && pwdata[`FSPS_CTRLA_EXEC];
	assign unlocked = unlock_q != 3'h0;
	// ==========================================
	// Trigger qualification
	logic        is_spm;
	logic        is_exec;
	logic        prot_ok;
	logic [4:0]  z_page;
	fsps_pkg::fsps_target_t tgt;
	logic        page_ok;
	logic        start_spm;
	logic        start_exec;
	logic        buf_clear;
	logic        buf_load;
	logic [15:0] buf_word;
	logic [3:0]  buf_rd;
	assign z_page = z_pointer[9:5];
	always_comb
	begin
		is_spm = 1'b0;
		is_exec = 1'b0;
		tgt = fsps_pkg::FSPS_TGT_ANY;
		unique case (cmd_q)
			`FSPS_CMD_ERPG, `FSPS_CMD_WRPG, `FSPS_CMD_EWPG, `FSPS_CMD_ERSIG, `FSPS_CMD_WRSIG:
				is_spm = 1'b1;
			`FSPS_CMD_ERAPP, `FSPS_CMD_ERAPPPG, `FSPS_CMD_WRAPPPG, `FSPS_CMD_EWAPPPG:
			begin
				is_spm = 1'b1;
				tgt = fsps_pkg::FSPS_TGT_APP;
			end
			`FSPS_CMD_ERBOOTPG, `FSPS_CMD_WRBOOTPG, `FSPS_CMD_EWBOOTPG:
			begin
				is_spm = 1'b1;
				tgt = fsps_pkg::FSPS_TGT_BOOT;
			end
			`FSPS_CMD_ERBUF, `FSPS_CMD_APPCRC, `FSPS_CMD_BOOTCRC, `FSPS_CMD_RNGCRC:
				is_exec = 1'b1;
			default:
			begin
				is_spm = 1'b0;
				is_exec = 1'b0;
			end
		endcase
	end
	// Section check on page commands; pointer bits above the page must be zero
	assign page_ok = z_pointer[23:10] == 14'h0 &&
		(tgt == fsps_pkg::FSPS_TGT_ANY ||
		(tgt == fsps_pkg::FSPS_TGT_APP && z_page < `FSPS_BOOT_FIRST) ||
		(tgt == fsps_pkg::FSPS_TGT_BOOT && z_page >= `FSPS_BOOT_FIRST)); // [RL13]
	assign prot_ok = unlocked; // [RL8]
	assign start_spm = spm_req && !busy_q && is_spm && prot_ok; // [RL18] [RL19]
	assign start_exec = exec_set && !busy_q && is_exec && prot_ok; // [RL18] [RL19]
	assign buf_load = spm_req && !busy_q && cmd_q == `FSPS_CMD_LDBUF; // [RL3]
	assign buf_word = spm_word;
	// ==========================================
	// Timed unlock window
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			unlock_q <= 3'h0;
		else if (apb_wr && paddr == `FSPS_OFF_UNLOCK && pwdata[7:0] == `FSPS_UNLOCK_KEY)
			unlock_q <= 3'(`FSPS_UNLOCK_CYC);
		else if (start_spm || start_exec)
			unlock_q <= 3'h0;
		else if (unlocked)
			unlock_q <= unlock_q - 3'h1;
	end
	// ==========================================
	// Page buffer and CRC engine
	fsps_crc_if crc_bus ();
	logic [15:0] buf_rd_word;
	assign buf_rd = widx_q;
	fsps_page_buf u_buf
	(
		.clk       (clk),
		.reset     (reset),
		.clear     (buf_clear),
		.load      (buf_load),
		.load_idx  (z_pointer[4:1]),
		.load_word (buf_word),
		.rd_idx    (buf_rd),
		.rd_word   (buf_rd_word)
	);
	fsps_crc u_crc
	(
		.clk   (clk),
		.reset (reset),
		.crc   (crc_bus)
	);
	assign crc_bus.clear = start_exec;
	assign crc_bus.step = state_q == fsps_pkg::FSPS_CRC && !crc_fin_q;
	assign crc_bus.word = flash_q[crc_pos_q];
	assign buf_clear = (state_q == fsps_pkg::FSPS_BUFCLR || state_q == fsps_pkg::FSPS_SIGCLR)
		&& timer_q == 16'h0; // [RL2] [RL17]
	// ==========================================
	// Sequencer
	logic range_bad;
	assign range_bad = lock_q != 8'hFF; // [RL11]
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			state_q <= fsps_pkg::FSPS_IDLE;
			timer_q <= 16'h0;
			page_q <= 5'h0;
			widx_q <= 4'h0;
			wr_after_q <= 1'b0;
			all_app_q <= 1'b0;
			crc_pos_q <= 9'h0;
			crc_end_q <= 9'h0;
			busy_q <= 1'b0;
			flash_section_busy_flag_q <= 1'b0;
			halt_q <= 1'b0;
			abort_q <= 1'b0;
		end
		else
		begin
			unique case (state_q)
				fsps_pkg::FSPS_IDLE:
				begin
					if (start_spm && !page_ok)
						abort_q <= 1'b1; // [RL13]
					else if (start_spm)
					begin
						abort_q <= 1'b0;
						busy_q <= 1'b1; // [RL6]
						page_q <= z_page; // [RL5] [RL7]
						widx_q <= 4'h0;
						timer_q <= `FSPS_ERASE_CYC;
						all_app_q <= cmd_q == `FSPS_CMD_ERAPP; // [RL12]
						wr_after_q <= cmd_q == `FSPS_CMD_EWPG || cmd_q == `FSPS_CMD_EWAPPPG
							|| cmd_q == `FSPS_CMD_EWBOOTPG; // [RL14]
						flash_section_busy_flag_q <= cmd_q != `FSPS_CMD_ERSIG && cmd_q != `FSPS_CMD_WRSIG;
						halt_q <= cmd_q == `FSPS_CMD_ERAPP || cmd_q == `FSPS_CMD_ERSIG
							|| cmd_q == `FSPS_CMD_WRSIG || tgt == fsps_pkg::FSPS_TGT_BOOT
							|| ((cmd_q == `FSPS_CMD_ERPG || cmd_q == `FSPS_CMD_WRPG
							|| cmd_q == `FSPS_CMD_EWPG) && z_page >= `FSPS_BOOT_FIRST);
						if (cmd_q == `FSPS_CMD_WRPG || cmd_q == `FSPS_CMD_WRAPPPG
							|| cmd_q == `FSPS_CMD_WRBOOTPG || cmd_q == `FSPS_CMD_WRSIG)
							state_q <= fsps_pkg::FSPS_WRITE;
						else if (cmd_q == `FSPS_CMD_ERAPP)
							state_q <= fsps_pkg::FSPS_ERAPP;
						else
							state_q <= fsps_pkg::FSPS_ERASE;
					end
					else if (start_exec && cmd_q == `FSPS_CMD_RNGCRC && range_bad)
						abort_q <= 1'b1; // [RL11]
					else if (start_exec && cmd_q == `FSPS_CMD_ERBUF)
					begin
						abort_q <= 1'b0;
						busy_q <= 1'b1; // [RL2]
						timer_q <= `FSPS_BUF_CYC;
						state_q <= fsps_pkg::FSPS_BUFCLR;
					end
					else if (start_exec)
					begin
						abort_q <= 1'b0;
						busy_q <= 1'b1; // [RL9] [RL15]
						halt_q <= 1'b1;
						state_q <= fsps_pkg::FSPS_CRC;
						unique case (cmd_q)
							`FSPS_CMD_APPCRC:
							begin
								crc_pos_q <= 9'h0;
								crc_end_q <= 9'h17F;
							end
							`FSPS_CMD_BOOTCRC:
							begin
								crc_pos_q <= 9'h180;
								crc_end_q <= 9'h1FF;
							end
							default:
							begin
								crc_pos_q <= addr_q[9:1]; // [RL9]
								crc_end_q <= data_q[9:1];
							end
						endcase
					end
				end
				fsps_pkg::FSPS_ERASE, fsps_pkg::FSPS_ERAPP:
				begin
					if (timer_q != 16'h0)
						timer_q <= timer_q - 16'h1;
					else if (wr_after_q)
					begin
						timer_q <= `FSPS_WRITE_CYC; // [RL14]
						state_q <= fsps_pkg::FSPS_WRITE;
					end
					else
						state_q <= fsps_pkg::FSPS_IDLE;
				end
				fsps_pkg::FSPS_WRITE:
				begin
					widx_q <= widx_q + 4'h1;
					if (widx_q == 4'hF)
					begin
						if (cmd_q == `FSPS_CMD_WRSIG)
						begin
							halt_q <= 1'b0; // [RL17]
							timer_q <= `FSPS_BUF_CYC;
							state_q <= fsps_pkg::FSPS_SIGCLR;
						end
						else
							state_q <= fsps_pkg::FSPS_IDLE;
					end
				end
				fsps_pkg::FSPS_CRC:
				begin
					crc_pos_q <= crc_pos_q + 9'h1;
					if (crc_fin_q)
						state_q <= fsps_pkg::FSPS_IDLE;
				end
				fsps_pkg::FSPS_BUFCLR, fsps_pkg::FSPS_SIGCLR:
				begin
					if (timer_q != 16'h0)
						timer_q <= timer_q - 16'h1;
					else
						state_q <= fsps_pkg::FSPS_IDLE;
				end
				default:
					state_q <= fsps_pkg::FSPS_IDLE;
			endcase
			if (state_q != fsps_pkg::FSPS_IDLE && state_q_done())
			begin
				busy_q <= 1'b0;
				flash_section_busy_flag_q <= 1'b0;
				halt_q <= 1'b0;
			end
		end
	end
	// Final cycle of any operation
	function automatic logic state_q_done();
		logic d;
		d = 1'b0;
		unique case (state_q)
			fsps_pkg::FSPS_ERASE, fsps_pkg::FSPS_ERAPP:
				d = timer_q == 16'h0 && !wr_after_q;
			fsps_pkg::FSPS_WRITE:
				d = widx_q == 4'hF && cmd_q != `FSPS_CMD_WRSIG;
			fsps_pkg::FSPS_CRC:
				d = crc_fin_q;
			fsps_pkg::FSPS_BUFCLR, fsps_pkg::FSPS_SIGCLR:
				d = timer_q == 16'h0;
			default:
				d = 1'b0;
		endcase
		return d;
	endfunction
	// ==========================================
	// Flash array; erase acts at the end of the erase wait, program one word per cycle in the write state
	logic erase_now;
	assign erase_now = (state_q == fsps_pkg::FSPS_ERASE || state_q == fsps_pkg::FSPS_ERAPP)
		&& timer_q == 16'h0;
	generate
		for (genvar g = 0; g < `FSPS_PAGES * `FSPS_WORDS; g++)
		begin : g_flash
			always_ff @(posedge clk or posedge reset)
			begin
				if (reset)
					flash_q[g] <= `FSPS_ERASED_WORD;
				else if (erase_now && cmd_q != `FSPS_CMD_ERSIG && (all_app_q ?
					5'(g / `FSPS_WORDS) < `FSPS_BOOT_FIRST : page_q == 5'(g / `FSPS_WORDS)))
					flash_q[g] <= `FSPS_ERASED_WORD; // [RL5] [RL12]
				else if (state_q == fsps_pkg::FSPS_WRITE && cmd_q != `FSPS_CMD_WRSIG
					&& {page_q, widx_q} == 9'(g))
					flash_q[g] <= flash_q[g] & buf_rd_word; // [RL4] [RL7]
			end
		end
		for (genvar s = 0; s < `FSPS_WORDS; s++)
		begin : g_sig
			always_ff @(posedge clk or posedge reset)
			begin
				if (reset)
					sig_q[s] <= `FSPS_ERASED_WORD;
				else if (erase_now && cmd_q == `FSPS_CMD_ERSIG)
					sig_q[s] <= `FSPS_ERASED_WORD; // [RL16]
				else if (state_q == fsps_pkg::FSPS_WRITE && cmd_q == `FSPS_CMD_WRSIG
					&& widx_q == 4'(s))
					sig_q[s] <= sig_q[s] & buf_rd_word; // [RL17]
			end
		end
	endgenerate
	// ==========================================
	// Program-memory load reads, answered next cycle
	logic [15:0] rd_word;
	assign rd_word = cmd_q == `FSPS_CMD_RDSIG ? sig_q[z_pointer[4:1]] : flash_q[z_pointer[9:1]];
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			lpm_data_q <= 8'h00;
			lpm_valid_q <= 1'b0;
		end
		else
		begin
			lpm_valid_q <= lpm_req && !busy_q
				&& (cmd_q == `FSPS_CMD_NOP || cmd_q == `FSPS_CMD_RDSIG); // [RL1]
			if (lpm_req)
				lpm_data_q <= z_pointer[0] ? rd_word[15:8] : rd_word[7:0]; // [RL1]
		end
	end
	// ==========================================
	// Software registers
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			cmd_q <= 7'h00;
			addr_q <= 24'h0;
			data_q <= 32'h0;
			lock_q <= 8'hFF;
		end
		else
		begin
			if (apb_wr && paddr == `FSPS_OFF_CMD)
				cmd_q <= pwdata[6:0];
			if (apb_wr && paddr == `FSPS_OFF_ADDR)
				addr_q <= pwdata[23:0];
			if (apb_wr && paddr == `FSPS_OFF_LOCK)
				lock_q <= lock_q & pwdata[7:0];
			if (state_q == fsps_pkg::FSPS_CRC && crc_fin_q)
				data_q <= crc_bus.value; // [RL10] [RL15]
			else if (apb_wr && paddr == `FSPS_OFF_DATA)
				data_q <= pwdata;
		end
	end
	// Extra cycle after the last word so busy falls only once the sum is readable
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			crc_fin_q <= 1'b0;
		else
			crc_fin_q <= state_q == fsps_pkg::FSPS_CRC && crc_pos_q == crc_end_q
				&& !crc_fin_q;
	end
	// ==========================================
	// APB slave: no wait states, error on unmapped offsets
	logic        hit;
	logic [31:0] rd_mux;
	always_comb
	begin
		hit = 1'b1;
		rd_mux = 32'h0;
		unique case (paddr)
			`FSPS_OFF_CMD:    rd_mux = {25'h0, cmd_q};
			`FSPS_OFF_CTRLA:  rd_mux = 32'h0;
			`FSPS_OFF_STATUS: rd_mux = {24'h0, busy_q, 5'h0, abort_q, flash_section_busy_flag_q};
			`FSPS_OFF_ADDR:   rd_mux = {8'h0, addr_q};
			`FSPS_OFF_DATA:   rd_mux = data_q;
			`FSPS_OFF_UNLOCK: rd_mux = {29'h0, unlock_q};
			`FSPS_OFF_LOCK:   rd_mux = {24'h0, lock_q};
			default:          hit = 1'b0;
		endcase
	end
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0;
		end
		else
		begin
			pready_q <= apb_setup;
			pslverr_q <= apb_setup && !hit;
			if (apb_setup)
				prdata_q <= rd_mux;
		end
	end
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign lpm_data = lpm_data_q;
	assign lpm_valid = lpm_valid_q;
	assign core_halt = halt_q; // [RL9]
	assign busy_flag = busy_q;
	assign flash_section_busy_flag = flash_section_busy_flag_q; // [RL6]
endmodule
`default_nettype wire

// ==== fsps_seq_properties.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "fsps_params.svh"
module fsps_seq_properties
(
	input wire logic        clk,
	input wire logic        reset,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        lpm_req,
	input wire logic        spm_req,
	input wire logic [23:0] z_pointer,
	input wire logic        lpm_valid,
	input wire logic        core_halt,
	input wire logic        busy_flag,
	input wire logic        flash_section_busy_flag
);
	// ==========================================
	// Shadow of command and unlock age
	logic       wr_done;
	logic [6:0] cmd_q;
	logic [3:0] age_q;
	assign wr_done = psel && penable && pready && pwrite;
	always_ff @(posedge clk or posedge reset)
		if (reset) cmd_q <= `FSPS_CMD_NOP;
		else if (wr_done && paddr == `FSPS_OFF_CMD) cmd_q <= pwdata[6:0];
	// Saturates so a stale unlock never looks fresh
	always_ff @(posedge clk or posedge reset)
		if (reset) age_q <= 4'hF;
		else if (wr_done && paddr == `FSPS_OFF_UNLOCK && pwdata[7:0] == `FSPS_UNLOCK_KEY)
			age_q <= 4'h0;
		else if (age_q != 4'hF) age_q <= age_q + 4'h1;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// ==========================================
	// Properties
	sequence s_armed;
		!busy_flag && age_q < 4'h3 && z_pointer[23:10] == 14'h0;
	endsequence
	sequence s_store(c);
		spm_req && cmd_q == c;
	endsequence
	property p_page_erase;
		s_store(`FSPS_CMD_ERPG) ##0 s_armed |=> busy_flag && flash_section_busy_flag;
	endproperty
	a_page_erase: assert property (p_page_erase) else $error("page erase not busy");
	property p_boot_halt;
		s_store(`FSPS_CMD_ERBOOTPG) ##0 s_armed ##0 z_pointer[9:5] >= `FSPS_BOOT_FIRST
			|=> core_halt && busy_flag;
	endproperty
	a_boot_halt: assert property (p_boot_halt) else $error("boot erase not halted");
	property p_bad_page;
		s_store(`FSPS_CMD_ERAPPPG) ##0 s_armed ##0 z_pointer[9:5] >= `FSPS_BOOT_FIRST
			|=> !busy_flag;
	endproperty
	a_bad_page: assert property (p_bad_page) else $error("bad page started");
	property p_no_unlock;
		spm_req && age_q == 4'hF && !busy_flag |=> !busy_flag;
	endproperty
	a_no_unlock: assert property (p_no_unlock) else $error("unprotected start");
	property p_erase_hold;
		$rose(flash_section_busy_flag) |-> flash_section_busy_flag[*8];
	endproperty
	a_erase_hold: assert property (p_erase_hold) else $error("flash busy too short");
	property p_flash_section_busy_flag_in_busy;
		flash_section_busy_flag |-> busy_flag;
	endproperty
	a_flash_section_busy_flag_in_busy: assert property (p_flash_section_busy_flag_in_busy) else $error("flash_section_busy_flag without busy");
	property p_halt_in_busy;
		core_halt |-> busy_flag;
	endproperty
	a_halt_in_busy: assert property (p_halt_in_busy) else $error("halt without busy");
	property p_lpm;
		lpm_req && !busy_flag && cmd_q == `FSPS_CMD_NOP |=> lpm_valid;
	endproperty
	a_lpm: assert property (p_lpm) else $error("load not answered");
	property p_lpm_cause;
		lpm_valid |-> $past(lpm_req);
	endproperty
	a_lpm_cause: assert property (p_lpm_cause) else $error("stray load answer");
	property p_crc_halt;
		wr_done && paddr == `FSPS_OFF_CTRLA && pwdata[0] && age_q < 4'h3 && !busy_flag
			&& (cmd_q == `FSPS_CMD_APPCRC || cmd_q == `FSPS_CMD_BOOTCRC)
			|=> core_halt && busy_flag;
	endproperty
	a_crc_halt: assert property (p_crc_halt) else $error("crc not halted");
endmodule
bind fsps_sequencer fsps_seq_properties u_props (.*);
`default_nettype wire

// ==== fsps_core_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module fsps_core_model
(
	input  wire logic        clk,
	input  wire logic        core_halt,
	input  wire logic        lpm_valid,
	input  wire logic [7:0]  lpm_data,
	output logic             lpm_req = 1'b0,
	output logic             spm_req = 1'b0,
	output logic      [23:0] z_pointer = 24'h0,
	output logic      [15:0] spm_word = 16'h0
);
	// ==========================================
	// Store and load instructions
	task automatic store(input logic [23:0] p, input logic [15:0] w);
		while (core_halt) @(posedge clk);
		spm_req <= 1'b1;
		z_pointer <= p;
		spm_word <= w;
		@(posedge clk);
		spm_req <= 1'b0;
		spm_word <= ~w; // Pair no longer meaningful
		@(posedge clk);
	endtask
	task automatic load(input logic [23:0] p, output logic [7:0] b);
		while (core_halt) @(posedge clk);
		lpm_req <= 1'b1;
		z_pointer <= p;
		@(posedge clk);
		lpm_req <= 1'b0;
		@(posedge clk);
		b = (lpm_valid === 1'b1) ? lpm_data : 8'hXX;
	endtask
endmodule
`default_nettype wire

// ==== flash_self_program_sequencer_test.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "fsps_params.svh"
module flash_self_program_sequencer_test;
	logic        clk = 1'b0;
	logic        reset = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        lpm_req;
	logic        spm_req;
	logic [23:0] z_pointer;
	logic [15:0] spm_word;
	logic [7:0]  lpm_data;
	logic        lpm_valid;
	logic        core_halt;
	logic        busy_flag;
	logic        flash_section_busy_flag;
	logic [31:0] rdata;
	logic        rerr;
	logic [31:0] seed;
	logic [4:0]  pg;
	logic [7:0]  b;
	logic [15:0] img [16];
	int          err_count = 0;
	int          n_checks = 0;
	int          cyc = 0;
	fsps_sequencer u_dut (.*);
	fsps_core_model u_core (.*);
	always #2.5 clk = ~clk;
	// ==========================================
	// Helpers
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
	endfunction
	function automatic logic [7:0] pick(input logic [15:0] w, input logic hi);
		return hi ? w[15:8] : w[7:0];
	endfunction
	// Range sum over words 0..31: only page p differs from the erased value
	function automatic logic [31:0] crc_exp(input logic [4:0] p);
		logic [31:0] c;
		logic [15:0] w;
		c = 32'hFFFFFFFF;
		for (int k = 0; k < 32; k++)
		begin
			w = 5'(k / 16) == p ? img[k % 16] : `FSPS_ERASED_WORD;
			for (int i = 0; i < 16; i++)
				c = lfsr(c ^ {w[i], 31'h0});
		end
		return c;
	endfunction
	task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("wrong value %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic close_out;
		if (err_count == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Bounded wait on the answer; idle edge after so psel never toggles in one step
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) err_count++;
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic unlock;
		wr(`FSPS_OFF_UNLOCK, 32'(`FSPS_UNLOCK_KEY));
	endtask
	task automatic wait_idle;
		int n;
		n = 0;
		while (busy_flag !== 1'b0 && n < 5000)
		begin
			@(posedge clk);
			n++;
		end
		if (busy_flag !== 1'b0) err_count++;
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			err_count++;
			close_out;
		end
	end
	// ==========================================
	// Scenarios
	initial
	begin
		seed = 32'hE9E01391;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		apb(1'b0, `FSPS_OFF_STATUS, 32'h0);
		check("status", rdata, 32'h0);
		apb(1'b0, `FSPS_OFF_LOCK, 32'h0);
		check("lock", rdata, 32'hFF);
		apb(1'b0, 12'h01C, 32'h0);
		check("slverr", 32'(rerr), 32'h1);
		wr(`FSPS_OFF_CMD, 32'(`FSPS_CMD_ERBUF));
		unlock();
		wr(`FSPS_OFF_CTRLA, 32'h1);
		check("buf busy", 32'(busy_flag), 32'h1);
		wait_idle();
		seed = lfsr(seed);
		pg = {1'b0, seed[3:0]} + 5'h1;
		for (int i = 0; i < 16; i++) img[i] = `FSPS_ERASED_WORD;
		wr(`FSPS_OFF_CMD, 32'(`FSPS_CMD_LDBUF));
		for (int k = 0; k < 4; k++)
		begin
			seed = lfsr(seed);
			img[seed[3:0]] = seed[31:16];
			u_core.store({14'h0, pg, seed[3:0], 1'b0}, seed[31:16]);
		end
		check("load busy", 32'(busy_flag), 32'h0);
		wr(`FSPS_OFF_CMD, 32'(`FSPS_CMD_ERPG));
		unlock();
		u_core.store({14'h0, pg, seed[4:0]}, 16'h0);
		check("erase flags", 32'({busy_flag, flash_section_busy_flag}), 32'h3);
		wait_idle();
		wr(`FSPS_OFF_CMD, 32'(`FSPS_CMD_WRPG));
		unlock();
		u_core.store({14'h0, pg, 5'h0}, 16'h0);
		wait_idle();
		wr(`FSPS_OFF_CMD, 32'(`FSPS_CMD_NOP));
		for (int i = 0; i < 32; i++)
		begin
			u_core.load({14'h0, pg, 5'(i)}, b);
			check("flash byte", 32'(b), 32'(pick(img[i / 2], i[0])));
		end
		wr(`FSPS_OFF_CMD, 32'(`FSPS_CMD_ERPG));
		u_core.store({14'h0, pg, 5'h0}, 16'h0);
		check("unlocked busy", 32'(busy_flag), 32'h0);
		wr(`FSPS_OFF_CMD, 32'(`FSPS_CMD_NOP));
		u_core.load({14'h0, pg, 5'h0}, b);
		check("kept byte", 32'(b), 32'(img[0][7:0]));
		wr(`FSPS_OFF_CMD, 32'(`FSPS_CMD_WRSIG));
		unlock();
		u_core.store(24'h0, 16'h0);
		wait_idle();
		wr(`FSPS_OFF_CMD, 32'(`FSPS_CMD_RDSIG));
		u_core.load(24'h0, b);
		check("sig byte", 32'(b), 32'(img[0][7:0]));
		wr(`FSPS_OFF_CMD, 32'(`FSPS_CMD_ERAPPPG));
		unlock();
		u_core.store({14'h0, 5'h18, 5'h0}, 16'h0);
		check("bad page busy", 32'(busy_flag), 32'h0);
		apb(1'b0, `FSPS_OFF_STATUS, 32'h0);
		check("abort", 32'(rdata[`FSPS_STAT_ABORT]), 32'h1);
		wr(`FSPS_OFF_CMD, 32'(`FSPS_CMD_ERBOOTPG));
		unlock();
		u_core.store({14'h0, 5'h1E, 5'h0}, 16'h0);
		check("boot halt", 32'(core_halt), 32'h1);
		wait_idle();
		wr(`FSPS_OFF_CMD, 32'(`FSPS_CMD_APPCRC));
		unlock();
		wr(`FSPS_OFF_CTRLA, 32'h1);
		check("app crc halt", 32'(core_halt), 32'h1);
		wait_idle();
		wr(`FSPS_OFF_ADDR, 32'h0);
		wr(`FSPS_OFF_DATA, 32'h3F);
		wr(`FSPS_OFF_CMD, 32'(`FSPS_CMD_RNGCRC));
		unlock();
		wr(`FSPS_OFF_CTRLA, 32'h1);
		check("range halt", 32'({busy_flag, core_halt}), 32'h3);
		wait_idle();
		apb(1'b0, `FSPS_OFF_DATA, 32'h0);
		check("crc landed", rdata, crc_exp(pg));
		wr(`FSPS_OFF_LOCK, 32'h0);
		wr(`FSPS_OFF_DATA, 32'h3F);
		unlock();
		wr(`FSPS_OFF_CTRLA, 32'h1);
		check("locked crc", 32'(busy_flag), 32'h0);
		close_out();
	end
endmodule
`default_nettype wire
